// file: verilog/ews_pkg.sv
package ews_pkg;

  // ----------------------------------------------------------------
  // register map (core memory-mapped register offsets)
  // ----------------------------------------------------------------
  localparam logic [6:0]  EWS_ADDR_COUNTS = 7'h28;
  localparam logic [6:0]  EWS_ADDR_CONFIG = 7'h2B;
  localparam logic [15:0] EWS_COUNTS_RST  = 16'h7FFF;
  localparam logic [15:0] EWS_CONFIG_RST  = 16'h0000;
  localparam logic [15:0] EWS_CONFIG_MASK = 16'h0001;

  // ----------------------------------------------------------------
  // field layout of external_wait_counts
  // ----------------------------------------------------------------
  localparam int EWS_FLD_W     = 3;
  localparam int EWS_LSB_IO    = 12;
  localparam int EWS_LSB_DHI   = 9;
  localparam int EWS_LSB_DLO   = 6;
  localparam int EWS_LSB_PHI   = 3;
  localparam int EWS_LSB_PLO   = 0;
  localparam int EWS_BIT_SPLIT = 15;
  localparam int EWS_BIT_DBL   = 0;
  localparam int EWS_HALF_BIT  = 15;  // address bit splitting a 64K page

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int EWS_ADDR_W = 23;
  localparam int EWS_CNT_W  = 4;     // up to fourteen extra cycles
  localparam logic [EWS_CNT_W-1:0] EWS_CNT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    EWS_SP_PROG = 2'h0,
    EWS_SP_DATA = 2'h1,
    EWS_SP_IO   = 2'h2
  } ews_space_t;

  typedef struct packed {
    ews_space_t              space;
    logic [EWS_ADDR_W-1:0]   addr;
  } ews_req_t;

  // gray sequence idle -> count -> ready -> done -> idle
  typedef enum logic [1:0] {
    EWS_ST_IDLE  = 2'b00,
    EWS_ST_COUNT = 2'b01,
    EWS_ST_READY = 2'b11,
    EWS_ST_DONE  = 2'b10
  } ews_state_t;

endpackage

// file: verilog/ews_down_counter.sv
`timescale 1ns/100ps
module ews_down_counter
  import ews_pkg::*;
#(
  parameter int CNT_W = EWS_CNT_W
)(
  input  wire logic             sys_clk,   // core machine clock
  input  wire logic             rst_b,     // async reset, active low
  input  wire logic             load,      // take a new count
  input  wire logic [CNT_W-1:0] load_val,  // count of wait cycles
  output logic                  expired    // count has reached zero
);

  logic [CNT_W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  // load wins over decrement so back to back accesses restart cleanly
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;                       // RULE16
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  assign expired = (cnt_r == '0);

endmodule

// file: verilog/ews_wait_state_gen.sv
`timescale 1ns/100ps
// Overview of operation
// RULE1: any external cycle may be stretched, software maximum fourteen extra cycles.
// RULE2: beyond that, the access stays held while external ready is low.
// RULE3: all ranges at zero waits turns the wait logic clock off.
// RULE4: low fifteen bits hold five 0..7 base counts, one per range.
// RULE5: after reset every range inserts seven wait states.
// RULE6: bits 14..12 give the base count for all I/O accesses.
// RULE7: bits 11..9 give the base count for upper data space.
// RULE8: bits 8..6 give the base count for lower data space.
// RULE9: split clear: bits 5..3 cover upper half of each program page.
// RULE10: split set: upper program field is ignored entirely.
// RULE11: bits 2..0 cover lower program half, or all program space if split.
// RULE12: bit 15, reset zero, chooses how program addresses are split.
// RULE13: config bit 0 scales counts by one or two; resets clear.
// RULE14: doubling gives up to fourteen waits; clear leaves counts unchanged.
// RULE15: config bits 15..1 read zero and ignore writes.
// RULE16: decode each access, load down-counter, hold until expired and ready.
module ews_wait_state_gen
  import ews_pkg::*;
(
  input  wire logic        sys_clk,          // core machine clock, 200 MHz
  input  wire logic        rst_b,            // async reset, active low
  // memory-mapped register port of the core
  input  wire logic        mmr_sel,          // register access this cycle
  input  wire logic        mmr_wr,           // 1 write, 0 read
  input  wire logic [6:0]  mmr_addr,         // register offset
  input  wire logic [15:0] mmr_wdata,        // write data
  output logic [15:0]      mmr_rdata_r,      // read data, one cycle later
  output logic             mmr_ack_r,        // register access answered
  // external access from the core
  input  wire logic        acc_start,        // one-cycle start of access
  input  wire ews_req_t    acc_req,          // space and address
  output logic             acc_hold_r,       // core must stall the cycle
  output logic             acc_done_r,       // one-cycle end of access
  // external pin and status
  input  wire logic        ext_ready_pin,    // external ready, active high
  output logic             wait_clk_on_r     // wait logic clock running
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0]          counts_r;
  logic [15:0]          config_r;
  ews_state_t           state_r;
  ews_state_t           state_nxt;
  logic                 ready_meta_r;
  logic                 ready_sync_r;
  logic [EWS_CNT_W-1:0] wait_nxt;
  logic                 cnt_load;
  logic                 cnt_expired;
  logic                 all_zero;
  logic                 wr_counts;
  logic                 wr_config;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // extract one 3-bit base field from the counts register
  function automatic logic [EWS_FLD_W-1:0] fld(input logic [15:0] r,
                                               input int lsb);
    fld = r[lsb +: EWS_FLD_W];
  endfunction

  // pick the base count for one access from space and address
  function automatic logic [EWS_FLD_W-1:0] base_for(
      input logic [15:0]           r,
      input ews_req_t              q);
    logic hi;
    hi = q.addr[EWS_HALF_BIT];
    case (q.space)
      EWS_SP_IO:   base_for = fld(r, EWS_LSB_IO);                 // RULE6
      EWS_SP_DATA: base_for = hi ? fld(r, EWS_LSB_DHI)            // RULE7
                                 : fld(r, EWS_LSB_DLO);           // RULE8
      EWS_SP_PROG: begin
        if (r[EWS_BIT_SPLIT]) begin                               // RULE12
          base_for = fld(r, EWS_LSB_PLO);                   // RULE10 RULE11
        end else begin
          base_for = hi ? fld(r, EWS_LSB_PHI)                     // RULE9
                        : fld(r, EWS_LSB_PLO);                    // RULE11
        end
      end
      default:     base_for = fld(r, EWS_LSB_IO);
    endcase
  endfunction

  // apply the one-or-two multiplier
  function automatic logic [EWS_CNT_W-1:0] scaled(
      input logic [EWS_FLD_W-1:0] b,
      input logic                 dbl);
    logic [EWS_CNT_W-1:0] w;
    w = {1'b0, b};
    scaled = dbl ? {w[EWS_CNT_W-2:0], 1'b0} : w;           // RULE13 RULE14
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_counts = mmr_sel && mmr_wr && (mmr_addr == EWS_ADDR_COUNTS);
  assign wr_config = mmr_sel && mmr_wr && (mmr_addr == EWS_ADDR_CONFIG);

  // all five base counts plus the split bit, writable as a whole word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      counts_r <= EWS_COUNTS_RST;                         // RULE5 RULE12
    end else if (wr_counts) begin
      counts_r <= mmr_wdata;                              // RULE4
    end
  end

  // only the multiplier bit is stored; the rest stay zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_r <= EWS_CONFIG_RST;                         // RULE13
    end else if (wr_config) begin
      config_r <= mmr_wdata & EWS_CONFIG_MASK;            // RULE15
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // unmapped offsets read as zero so the core bus never sees junk
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mmr_rdata_r <= 16'h0000;
      mmr_ack_r   <= 1'b0;
    end else begin
      mmr_ack_r <= mmr_sel;
      if (mmr_sel && !mmr_wr) begin
        case (mmr_addr)
          EWS_ADDR_COUNTS: mmr_rdata_r <= counts_r;
          EWS_ADDR_CONFIG: mmr_rdata_r <= config_r;       // RULE15
          default:         mmr_rdata_r <= 16'h0000;
        endcase
      end else begin
        mmr_rdata_r <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // ready pin synchroniser
  // ----------------------------------------------------------------
  // the pin is asynchronous to the core clock; only the second stage
  // is looked at by the sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_meta_r <= 1'b0;
      ready_sync_r <= 1'b0;
    end else begin
      ready_meta_r <= ext_ready_pin;
      ready_sync_r <= ready_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // zero-wait detection and clock gating
  // ----------------------------------------------------------------
  // upper program field does not count while the split bit is set
  assign all_zero =
      (fld(counts_r, EWS_LSB_IO)  == '0) &&
      (fld(counts_r, EWS_LSB_DHI) == '0) &&
      (fld(counts_r, EWS_LSB_DLO) == '0) &&
      (fld(counts_r, EWS_LSB_PLO) == '0) &&
      (counts_r[EWS_BIT_SPLIT] ||
       (fld(counts_r, EWS_LSB_PHI) == '0));                // RULE10

  // modelled as an enable on the counter load: when off, the counter
  // is never loaded, though a count already loaded still runs down to zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_clk_on_r <= 1'b1;
    end else begin
      wait_clk_on_r <= !all_zero;                         // RULE3
    end
  end

  // ----------------------------------------------------------------
  // wait count of the access being started
  // ----------------------------------------------------------------
  assign wait_nxt = scaled(base_for(counts_r, acc_req),
                           config_r[EWS_BIT_DBL]);        // RULE1
  assign cnt_load = (state_r == EWS_ST_IDLE) && acc_start &&
                    wait_clk_on_r && (wait_nxt != EWS_CNT_ZERO);

  ews_down_counter #(
    .CNT_W    (EWS_CNT_W)
  ) u_cnt (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .load     (cnt_load),
    .load_val (wait_nxt),
    .expired  (cnt_expired)
  );

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EWS_ST_IDLE: begin
        if (acc_start) begin
          state_nxt = cnt_load ? EWS_ST_COUNT : EWS_ST_READY; // RULE16
        end
      end
      EWS_ST_COUNT: begin
        if (cnt_expired) begin
          state_nxt = EWS_ST_READY;
        end
      end
      EWS_ST_READY: begin
        if (ready_sync_r) begin
          state_nxt = EWS_ST_DONE;                        // RULE2
        end
      end
      EWS_ST_DONE:  state_nxt = EWS_ST_IDLE;
      default:      state_nxt = EWS_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= EWS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // hold covers counting and the ready wait; done pulses at the end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_hold_r <= 1'b0;
      acc_done_r <= 1'b0;
    end else begin
      acc_hold_r <= (state_nxt == EWS_ST_COUNT) ||
                    (state_nxt == EWS_ST_READY);          // RULE16
      acc_done_r <= (state_nxt == EWS_ST_DONE);
    end
  end

endmodule

// file: bench/ews_wait_state_gen_checker.sv
`timescale 1ns/100ps
module ews_wait_state_gen_checker
  import ews_pkg::*;
(
  input wire logic        sys_clk,        // core clock
  input wire logic        rst_b,          // reset, active low
  input wire logic        mmr_sel,        // register access
  input wire logic        mmr_wr,         // write strobe
  input wire logic [6:0]  mmr_addr,       // register offset
  input wire logic [15:0] mmr_rdata_r,    // read data
  input wire logic        mmr_ack_r,      // access answered
  input wire logic        acc_start,      // access start
  input wire logic        acc_hold_r,     // access stretched
  input wire logic        acc_done_r,     // access ended
  input wire logic        ext_ready_pin   // external ready
);
  logic [4:0] rdy_cnt_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ready-high cycles in one stretch; a stall must not add to this bound
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rdy_cnt_r <= 5'h00;
    else if (!acc_hold_r) rdy_cnt_r <= 5'h00;
    else if (ext_ready_pin) rdy_cnt_r <= rdy_cnt_r + 5'h01;
  end
  property p_ack; mmr_sel |=> mmr_ack_r; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_no_ack; !mmr_sel |=> !mmr_ack_r; endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_rd_idle; !mmr_sel || mmr_wr |=> mmr_rdata_r == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
  property p_cfg_rsvd;
    mmr_sel && !mmr_wr && mmr_addr == EWS_ADDR_CONFIG
      |=> mmr_rdata_r[15:1] == 15'h0000;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved set");
  property p_done_pulse; acc_done_r |=> !acc_done_r; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done long");
  property p_done_ends; $fell(acc_hold_r) |-> acc_done_r; endproperty
  a_done_ends: assert property (p_done_ends) else $error("hold fell");
  property p_hold_cause; $rose(acc_hold_r) |-> $past(acc_start); endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("no start");
  property p_ready_stall;
    (acc_hold_r && !ext_ready_pin) [*4] |=> !acc_done_r;
  endproperty
  a_ready_stall: assert property (p_ready_stall) else $error("ready low");
  property p_max_hold; rdy_cnt_r <= 5'h14; endproperty
  a_max_hold: assert property (p_max_hold) else $error("stretch long");
  c_stall: cover property ((acc_hold_r && !ext_ready_pin) [*4]);
  c_done: cover property (acc_done_r);
  c_cfg: cover property (mmr_sel && mmr_wr && mmr_addr == EWS_ADDR_CONFIG);
endmodule

// file: bench/ews_ext_device.sv
`timescale 1ns/100ps
module ews_ext_device (
  input  wire logic       sys_clk,       // core clock
  input  wire logic       rst_b,         // reset, active low
  input  wire logic       acc_hold_r,    // access being stretched
  input  wire logic [7:0] stall_len,     // cycles to keep ready low
  output logic            ext_ready_pin  // ready, high when done
);
  logic       hold_d_r;
  logic [7:0] left_r;
  // a slow device pulls ready low as soon as it sees a stretched cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_d_r <= 1'b0;
      left_r   <= 8'h00;
    end else begin
      hold_d_r <= acc_hold_r;
      if (acc_hold_r && !hold_d_r) left_r <= stall_len;
      else if (left_r != 8'h00) left_r <= left_r - 8'h01;
    end
  end
  assign ext_ready_pin = (left_r == 8'h00);
endmodule

// file: bench/ews_wait_state_gen_tb.sv
`timescale 1ns/100ps
module ews_wait_state_gen_tb
  import ews_pkg::*;
;
  logic        sys_clk, rst_b, mmr_sel, mmr_wr, acc_start;
  logic [6:0]  mmr_addr;
  logic [15:0] mmr_wdata, mmr_rdata_r;
  logic        mmr_ack_r, acc_hold_r, acc_done_r, ext_ready_pin, wait_clk_on_r;
  ews_req_t    acc_req;
  logic [7:0]  stall_len;
  int          num_errors, check_count, cycles, lat;
  ews_wait_state_gen uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .mmr_sel(mmr_sel), .mmr_wr(mmr_wr), .mmr_addr(mmr_addr),
    .mmr_wdata(mmr_wdata), .mmr_rdata_r(mmr_rdata_r), .mmr_ack_r(mmr_ack_r),
    .acc_start(acc_start), .acc_req(acc_req), .acc_hold_r(acc_hold_r),
    .acc_done_r(acc_done_r), .ext_ready_pin(ext_ready_pin),
    .wait_clk_on_r(wait_clk_on_r));
  ews_ext_device u_dev (.sys_clk(sys_clk), .rst_b(rst_b),
    .acc_hold_r(acc_hold_r), .stall_len(stall_len),
    .ext_ready_pin(ext_ready_pin));
  always #2.5 sys_clk = ~sys_clk;
  // -----------------------------------------------------------
  // shared bus tasks
  // -----------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    mmr_sel <= 1'b1; mmr_wr <= 1'b1; mmr_addr <= a; mmr_wdata <= d;
    @(posedge sys_clk);
    mmr_sel <= 1'b0;
  endtask
  task automatic reg_rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    mmr_sel <= 1'b1; mmr_wr <= 1'b0; mmr_addr <= a;
    @(posedge sys_clk);
    mmr_sel <= 1'b0;
    @(negedge sys_clk);
    chk("ack", {15'h0000, mmr_ack_r}, 16'h0001);
    chk("rdata", mmr_rdata_r, e);
  endtask
  // latency counted in edges from the one that takes the start
  task automatic run(input ews_space_t sp, input logic [22:0] a);
    @(posedge sys_clk);
    acc_start <= 1'b1; acc_req <= '{space: sp, addr: a};
    @(posedge sys_clk);
    acc_start <= 1'b0;
    lat = 0;
    while (acc_done_r !== 1'b1 && lat < 200) begin
      @(posedge sys_clk);
      #1 lat++;
    end
  endtask
  // edges after the taking edge: counter counts n down over n edges, one ready
  // cycle, then done; with no waits the ready cycle follows directly
  task automatic acc(input ews_space_t sp, input logic [22:0] a, input int n);
    run(sp, a);
    chk("latency", 16'(lat), 16'(n == 0 ? 1 : n + 2));
  endtask
  // a start while busy is ignored: one access, latency of the first start
  task automatic t_busy;
    @(posedge sys_clk);
    acc_start <= 1'b1;
    acc_req   <= '{space: EWS_SP_IO, addr: 23'h000020};
    repeat (3) @(posedge sys_clk);
    acc_start <= 1'b0;
    lat = 0;
    while (acc_done_r !== 1'b1 && lat < 200) begin
      @(posedge sys_clk);
      #1 lat++;
    end
    chk("busy_lat", 16'(lat), 16'h0007);
    repeat (4) @(posedge sys_clk);
    #1 chk("busy_hold", {15'h0000, acc_hold_r}, 16'h0000);
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_reset;
    reg_rd(EWS_ADDR_COUNTS, 16'h7FFF);
    reg_rd(EWS_ADDR_CONFIG, 16'h0000);
    acc(EWS_SP_IO, 23'h000000, 7);
    acc(EWS_SP_PROG, 23'h018000, 7);
  endtask
  task automatic t_regs;
    reg_wr(EWS_ADDR_CONFIG, 16'hFFFF);
    reg_rd(EWS_ADDR_CONFIG, 16'h0001);
    reg_wr(7'h30, 16'hFFFF);
    reg_rd(7'h30, 16'h0000);
  endtask
  task automatic t_ranges;
    reg_wr(EWS_ADDR_COUNTS, 16'h14E5);
    for (int m = 1; m <= 2; m++) begin
      reg_wr(EWS_ADDR_CONFIG, 16'(m - 1));
      acc(EWS_SP_IO, 23'h00FFFF, m);
      acc(EWS_SP_DATA, 23'h008000, 2 * m);
      acc(EWS_SP_DATA, 23'h007FFF, 3 * m);
      acc(EWS_SP_PROG, 23'h01C000, 4 * m);
      acc(EWS_SP_PROG, 23'h010000, 5 * m);
    end
    reg_wr(EWS_ADDR_COUNTS, 16'h94E5);
    reg_rd(EWS_ADDR_COUNTS, 16'h94E5);
    acc(EWS_SP_PROG, 23'h01C000, 10);
    acc(EWS_SP_PROG, 23'h0F8000, 10);
    reg_wr(EWS_ADDR_COUNTS, 16'h7FFF);
    acc(EWS_SP_DATA, 23'h000000, 14);
  endtask
  task automatic t_zero;
    reg_wr(EWS_ADDR_CONFIG, 16'h0000);
    reg_wr(EWS_ADDR_COUNTS, 16'h0000);
    acc(EWS_SP_DATA, 23'h000000, 0);
    chk("clk_on", {15'h0000, wait_clk_on_r}, 16'h0000);
    reg_wr(EWS_ADDR_COUNTS, 16'h8038);
    acc(EWS_SP_PROG, 23'h008000, 0);
    chk("clk_on", {15'h0000, wait_clk_on_r}, 16'h0000);
  endtask
  task automatic t_stall;
    reg_wr(EWS_ADDR_COUNTS, 16'h7FFF);
    stall_len <= 8'h14;
    run(EWS_SP_IO, 23'h000010);
    chk("stall", 16'(lat >= 23 && lat <= 26), 16'h0001);
    chk("clk_on", {15'h0000, wait_clk_on_r}, 16'h0001);
    @(posedge sys_clk);
    stall_len <= 8'h00;
    acc(EWS_SP_IO, 23'h000010, 7);
  endtask
  // -----------------------------------------------------------
  // sequence and verdict
  // -----------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // the whole run is well under two thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done;
    end
  end
  initial begin
    sys_clk = 1'b0; rst_b = 1'b0; mmr_sel = 1'b0; mmr_wr = 1'b0;
    mmr_addr = 7'h00; mmr_wdata = 16'h0000; acc_start = 1'b0;
    acc_req = '0; stall_len = 8'h00;
    num_errors = 0; check_count = 0; cycles = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_regs;
    t_ranges;
    t_zero;
    t_stall;
    t_busy;
    test_done;
  end
endmodule
bind ews_wait_state_gen ews_wait_state_gen_checker u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .mmr_sel(mmr_sel), .mmr_wr(mmr_wr),
  .mmr_addr(mmr_addr), .mmr_rdata_r(mmr_rdata_r), .mmr_ack_r(mmr_ack_r),
  .acc_start(acc_start), .acc_hold_r(acc_hold_r),
  .acc_done_r(acc_done_r), .ext_ready_pin(ext_ready_pin));
